// *** hw/timer3_defs.vh ***
// Register offsets, field positions, reset values and clock divide counts for timer three.
`ifndef TIMER3_DEFS_VH
`define TIMER3_DEFS_VH
`define T3_CTRL_ADDR 8'h91
`define T3_RLL_ADDR 8'h92
`define T3_RLH_ADDR 8'h93
`define T3_CNTL_ADDR 8'h94
`define T3_CNTH_ADDR 8'h95
`define T3_CTRL_RESET 8'h00
`define T3_RLD_RESET 8'h00
`define T3_CNT_RESET 8'h00
`define T3_BIT_UPPER_FLAG 7
`define T3_BIT_LOWER_FLAG 6
`define T3_BIT_LOWER_IRQ_EN 5
`define T3_BIT_CAPTURE_EN 4
`define T3_BIT_SPLIT 3
`define T3_BIT_RUN 2
`define T3_BIT_RESERVED 1
`define T3_BIT_EXT_SEL 0
`define T3_SYS_DIV 4'd12
`define T3_EXT_DIV 4'd8
`endif

// *** hw/tick_divider.v ***
// Divides a qualified input event stream into a one-cycle tick every N events.
`timescale 1ns/10ps
module tick_divider
#(
  parameter [3:0] DIV = 4'd12
)
(
  // Clock and reset.
  input wire sys_clk,
  input wire rst_b,
  // Event in, tick out.
  input wire event_in,
  output reg tick
);

  reg [3:0] cnt_q;

  // Counts events and pulses tick on the last of every DIV.
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      cnt_q <= 4'h0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (event_in)
      begin
        if (cnt_q == DIV - 4'd1)
        begin
          cnt_q <= 4'h0;
          tick <= 1'b1;
        end
        else
        begin
          cnt_q <= cnt_q + 4'd1;
        end
      end
    end
  end

endmodule

// *** hw/timer3_autoreload_capture.v ***
// Sixteen-bit auto-reload timer with split byte mode and oscillator capture.
//
// What this block does
// - Set upper flag when high byte wraps FF to 00, or FFFF to 0000.
// - Request interrupt when upper flag sets and timer interrupt enabled.
// - Overflow flags stay set until software clears them.
// - Set lower flag whenever low byte wraps, in every mode.
// - With lower interrupt enable also request interrupt on low overflows.
// - Capture enabled: oscillator falling edge copies count to reloads, interrupts.
// - Split bit 0 gives one 16-bit counter, 1 gives two 8-bit counters.
// - Run bit enables counting; in split mode it gates only the high byte.
// - Count clock is system clock over 12, or external clock over 8.
// - Per-byte clock choice selects the raw system clock over the divided count clock; the lower choice also acts in 16-bit mode.
// - Low reload supplies low reload byte and receives captured low byte.
// - High reload supplies high reload byte and receives captured high byte.
`timescale 1ns/10ps
`include "timer3_defs.vh"
module timer3_autoreload_capture
(
  // Clock and reset.
  input wire sys_clk,
  input wire rst_b,
  // Special-function register port.
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata,
  // Clock sources and selects.
  input wire ext_clk,
  input wire upper_clock_choice,
  input wire lower_clock_choice,
  // Capture source.
  input wire lfo_out,
  // Interrupt side.
  input wire timer_irq_en,
  output reg timer_irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg upper_overflow_flag_q;
  reg lower_overflow_flag_q;
  reg lower_overflow_irq_en_q;
  reg lfo_capture_en_q;
  reg split_byte_mode_q;
  reg run_control_q;
  reg ext_clock_select_q;
  reg [7:0] reload_low_q;
  reg [7:0] reload_high_q;
  reg [7:0] count_lower_byte_q;
  reg [7:0] count_upper_byte_q;
  reg ext_clk_q;
  reg lfo_q;
  wire sys_tick;
  wire ext_tick;

  // ----------------------------------------------------------------
  // Count clock generation
  // ----------------------------------------------------------------

  // System clock divided by twelve. The divider runs free from reset, so the first
  // count after the run bit is set lands anywhere within twelve cycles; software that
  // needs an exact first interval must preload the count to allow for it.
  tick_divider #(.DIV(`T3_SYS_DIV)) u_sys_div
  (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .event_in(1'b1),
    .tick(sys_tick)
  );

  // External clock rising edges divided by eight.
  tick_divider #(.DIV(`T3_EXT_DIV)) u_ext_div
  (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .event_in(ext_clk & ~ext_clk_q),
    .tick(ext_tick)
  );

  // Edge history for the external clock and the oscillator output.
  // Both reset low, so no false oscillator falling edge can follow reset; a high external
  // clock at reset counts as one rising edge, an eighth of a count at most.
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      ext_clk_q <= 1'b0;
      lfo_q <= 1'b0;
    end
    else
    begin
      ext_clk_q <= ext_clk;
      lfo_q <= lfo_out;
    end
  end

  // ----------------------------------------------------------------
  // Counting decisions
  // ----------------------------------------------------------------
  reg base_tick;
  reg low_tick;
  reg high_tick;
  reg low_wrap;
  reg high_wrap;
  reg low_inc;
  reg high_inc;
  reg capture;

  // Selects count ticks and finds wraps and captures for this cycle.
  always @*
  begin
    base_tick = ext_clock_select_q ? ext_tick : sys_tick;
    if (split_byte_mode_q)
    begin
      // Each byte picks the divided count clock or the raw system clock.
      low_tick = lower_clock_choice ? 1'b1 : base_tick;
      high_tick = upper_clock_choice ? 1'b1 : base_tick;
      low_inc = low_tick;
      high_inc = high_tick & run_control_q;
      low_wrap = low_inc && (count_lower_byte_q == 8'hff);
      high_wrap = high_inc && (count_upper_byte_q == 8'hff);
    end
    else
    begin
      low_tick = lower_clock_choice ? 1'b1 : base_tick;
      high_tick = low_tick;
      low_inc = low_tick & run_control_q;
      low_wrap = low_inc && (count_lower_byte_q == 8'hff);
      high_inc = low_wrap;
      high_wrap = low_wrap && (count_upper_byte_q == 8'hff);
    end
    capture = lfo_capture_en_q & lfo_q & ~lfo_out;
  end

  // ----------------------------------------------------------------
  // Register writes, counters, flags and capture
  // ----------------------------------------------------------------
  wire wr_ctrl = sfr_wr && (sfr_addr == `T3_CTRL_ADDR);
  wire wr_rll = sfr_wr && (sfr_addr == `T3_RLL_ADDR);
  wire wr_rlh = sfr_wr && (sfr_addr == `T3_RLH_ADDR);
  wire wr_cntl = sfr_wr && (sfr_addr == `T3_CNTL_ADDR);
  wire wr_cnth = sfr_wr && (sfr_addr == `T3_CNTH_ADDR);
  wire low_set = low_wrap;
  // The upper flag marks a high byte wrap; in 16-bit mode that is the full count wrap.
  wire high_set = high_wrap;
  wire up_flag_d = (wr_ctrl ? sfr_wdata[`T3_BIT_UPPER_FLAG] : upper_overflow_flag_q)
                   | high_set;
  wire lo_flag_d = (wr_ctrl ? sfr_wdata[`T3_BIT_LOWER_FLAG] : lower_overflow_flag_q)
                   | low_set;

  // Control bits; hardware set wins over a software clear in the same cycle.
  // The reserved bit is not stored, so a stray one written there has no effect.
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      upper_overflow_flag_q <= 1'b0;
      lower_overflow_flag_q <= 1'b0;
      lower_overflow_irq_en_q <= 1'b0;
      lfo_capture_en_q <= 1'b0;
      split_byte_mode_q <= 1'b0;
      run_control_q <= 1'b0;
      ext_clock_select_q <= 1'b0;
    end
    else
    begin
      upper_overflow_flag_q <= up_flag_d;
      lower_overflow_flag_q <= lo_flag_d;
      if (wr_ctrl)
      begin
        lower_overflow_irq_en_q <= sfr_wdata[`T3_BIT_LOWER_IRQ_EN];
        lfo_capture_en_q <= sfr_wdata[`T3_BIT_CAPTURE_EN];
        split_byte_mode_q <= sfr_wdata[`T3_BIT_SPLIT];
        run_control_q <= sfr_wdata[`T3_BIT_RUN];
        ext_clock_select_q <= sfr_wdata[`T3_BIT_EXT_SEL];
      end
    end
  end

  // Reload registers: software writes, overwritten by a capture.
  // A capture in the same cycle as a reload write wins, so the captured count is
  // never lost; the write is dropped and software must repeat it if it matters.
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      reload_low_q <= `T3_RLD_RESET;
      reload_high_q <= `T3_RLD_RESET;
    end
    else if (capture)
    begin
      reload_low_q <= count_lower_byte_q;
      reload_high_q <= count_upper_byte_q;
    end
    else
    begin
      if (wr_rll)
      begin
        reload_low_q <= sfr_wdata;
      end
      if (wr_rlh)
      begin
        reload_high_q <= sfr_wdata;
      end
    end
  end

  // Count bytes: increment, reload on wrap, software write wins.
  // In 16-bit mode the low byte passes through zero on its own wraps and reloads only
  // when the whole count wraps, so both bytes take their reload values together.
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      count_lower_byte_q <= `T3_CNT_RESET;
      count_upper_byte_q <= `T3_CNT_RESET;
    end
    else
    begin
      if (wr_cntl)
      begin
        count_lower_byte_q <= sfr_wdata;
      end
      else if (split_byte_mode_q ? low_wrap : high_wrap)
      begin
        count_lower_byte_q <= reload_low_q;
      end
      else if (low_inc)
      begin
        count_lower_byte_q <= count_lower_byte_q + 8'h01;
      end
      if (wr_cnth)
      begin
        count_upper_byte_q <= sfr_wdata;
      end
      else if (high_wrap)
      begin
        count_upper_byte_q <= reload_high_q;
      end
      else if (high_inc)
      begin
        count_upper_byte_q <= count_upper_byte_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request and read data
  // ----------------------------------------------------------------

  // Interrupt causes. The flag terms use next flag values, so the request rises at
  // the edge that sets a flag, whether hardware or a software write of one sets it.
  wire irq_upper = up_flag_d;
  wire irq_lower = lower_overflow_irq_en_q & lo_flag_d;
  wire irq_capture = capture;
  wire irq_any = irq_upper | irq_lower | irq_capture;

  // Request is a level that follows the flags, plus a one-cycle capture pulse.
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      timer_irq <= 1'b0;
    end
    else
    begin
      timer_irq <= timer_irq_en & irq_any;
    end
  end

  reg [7:0] read_mux;

  // Selects the addressed register; the reserved bit and unmapped addresses read zero.
  always @*
  begin
    read_mux = 8'h00;
    case (sfr_addr)
      `T3_CTRL_ADDR: read_mux = {upper_overflow_flag_q, lower_overflow_flag_q,
                                 lower_overflow_irq_en_q, lfo_capture_en_q,
                                 split_byte_mode_q, run_control_q, 1'b0,
                                 ext_clock_select_q};
      `T3_RLL_ADDR: read_mux = reload_low_q;
      `T3_RLH_ADDR: read_mux = reload_high_q;
      `T3_CNTL_ADDR: read_mux = count_lower_byte_q;
      `T3_CNTH_ADDR: read_mux = count_upper_byte_q;
      default: read_mux = 8'h00;
    endcase
  end

  // Read data is registered on a read strobe and holds until the next read.
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      sfr_rdata <= 8'h00;
    end
    else if (sfr_rd)
    begin
      sfr_rdata <= read_mux;
    end
  end

endmodule

// *** verification/timer3_checker_asserts.sv ***
// Concurrent checks on the timer three register port and interrupt request.
`timescale 1ns/10ps
module timer3_checker
(
  // Watched ports.
  input wire sys_clk,
  input wire rst_b,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_rdata,
  input wire lfo_out,
  input wire timer_irq_en,
  input wire timer_irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // Register port answers.
  chk_unmapped_read_zero: assert property (
    sfr_rd && (sfr_addr < 8'h91 || sfr_addr > 8'h95) |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  chk_reserved_reads_zero: assert property (
    sfr_rd && sfr_addr == 8'h91 |=> !sfr_rdata[1]) else $error("reserved bit set");
  chk_ctrl_readback: assert property (
    sfr_wr && sfr_addr == 8'h91 ##1 !sfr_wr ##1 sfr_rd && !sfr_wr && sfr_addr == 8'h91
    |=> (sfr_rdata & 8'h3d) == ($past(sfr_wdata, 3) & 8'h3d)) else $error("control lost");
  chk_low_reload_kept: assert property (
    sfr_wr && sfr_addr == 8'h92 && lfo_out ##1 !sfr_wr && lfo_out
    ##1 sfr_rd && !sfr_wr && sfr_addr == 8'h92
    |=> sfr_rdata == $past(sfr_wdata, 3)) else $error("low reload lost");
  chk_high_reload_kept: assert property (
    sfr_wr && sfr_addr == 8'h93 && lfo_out ##1 !sfr_wr && lfo_out
    ##1 sfr_rd && !sfr_wr && sfr_addr == 8'h93
    |=> sfr_rdata == $past(sfr_wdata, 3)) else $error("high reload lost");
  // Interrupt request follows its enable and the flags.
  chk_irq_needs_enable: assert property (!timer_irq_en |=> !timer_irq)
    else $error("request while disabled");
  chk_irq_rise_cause: assert property ($rose(timer_irq) |-> $past(timer_irq_en))
    else $error("request rose without enable");
  chk_flag_write_irq: assert property (
    sfr_wr && sfr_addr == 8'h91 && sfr_wdata[7] && timer_irq_en ##1 timer_irq_en && !sfr_wr
    |=> timer_irq) else $error("flag write gave no request");
  cov_flag_irq: cover property (sfr_wr && sfr_addr == 8'h91 && sfr_wdata[7] ##2 timer_irq);
  cov_capture_irq: cover property ($fell(lfo_out) ##[1:4] timer_irq);
  cov_unmapped: cover property (sfr_rd && sfr_addr == 8'h96);
endmodule
bind timer3_autoreload_capture timer3_checker timer3_checker_inst (.sys_clk(sys_clk),
  .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .lfo_out(lfo_out),
  .timer_irq_en(timer_irq_en), .timer_irq(timer_irq));

// *** verification/tb_top.sv ***
// Self-checking bench for the timer three block.
`timescale 1ns/10ps
module tb_top;
  logic sys_clk = 1'b0, rst_b = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, ext_clk = 1'b0;
  logic upper_clock_choice = 1'b0, lower_clock_choice = 1'b0, lfo_out = 1'b1;
  logic timer_irq_en = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
  wire [7:0] sfr_rdata;
  wire timer_irq;
  int mismatches = 0, compares = 0;
  timer3_autoreload_capture timer3_autoreload_capture_inst (.sys_clk(sys_clk),
    .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .ext_clk(ext_clk),
    .upper_clock_choice(upper_clock_choice), .lower_clock_choice(lower_clock_choice),
    .lfo_out(lfo_out), .timer_irq_en(timer_irq_en), .timer_irq(timer_irq));
  // Clock of 100 ns.
  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end
  // Prints the verdict and ends the run.
  task complete_run;
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    #1 chk(sfr_rdata, e);
  endtask
  // Waits a bounded time for the request to reach a level.
  task wait_irq(input logic v);
    int i;
    i = 0;
    while (timer_irq !== v && i < 20)
    begin
      @(posedge sys_clk);
      #1 i++;
    end
    chk({7'h00, timer_irq}, {7'h00, v});
    if (i == 20) complete_run();
  endtask
  // Main sequence.
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    timer_irq_en <= 1'b1;
    wr(8'h96, 8'hff);
    for (int i = 1; i < 7; i++) rd(8'h90 + i[7:0], 8'h00);
    wr(8'h91, 8'h3d);
    rd(8'h91, 8'h3d);
    wr(8'h91, 8'h00);
    wr(8'h92, 8'h34);
    rd(8'h92, 8'h34);
    wr(8'h93, 8'h12);
    rd(8'h93, 8'h12);
    @(posedge sys_clk);
    lower_clock_choice <= 1'b1;
    upper_clock_choice <= 1'b1;
    wr(8'h94, 8'hfe);
    wr(8'h95, 8'hff);
    wr(8'h91, 8'h04);
    wait_irq(1'b1);
    rd(8'h95, 8'h12);
    repeat (5) @(posedge sys_clk);
    rd(8'h91, 8'hc4);
    wr(8'h91, 8'h00);
    wait_irq(1'b0);
    wr(8'h91, 8'h80);
    wait_irq(1'b1);
    wr(8'h91, 8'h00);
    wait_irq(1'b0);
    @(posedge sys_clk);
    timer_irq_en <= 1'b0;
    wr(8'h91, 8'h80);
    repeat (2) @(posedge sys_clk);
    #1 chk({7'h00, timer_irq}, 8'h00);
    rd(8'h91, 8'h80);
    wr(8'h91, 8'h00);
    timer_irq_en <= 1'b1;
    wr(8'h92, 8'hf0);
    wr(8'h95, 8'h55);
    wr(8'h94, 8'hfc);
    wr(8'h91, 8'h28);
    wait_irq(1'b1);
    rd(8'h95, 8'h55);
    rd(8'h91, 8'h68);
    wr(8'h91, 8'h00);
    wait_irq(1'b0);
    @(posedge sys_clk);
    lower_clock_choice <= 1'b0;
    wr(8'h94, 8'h00);
    wr(8'h91, 8'h04);
    repeat (118) @(posedge sys_clk);
    wr(8'h91, 8'h00);
    rd(8'h94, 8'h0a);
    wr(8'h94, 8'h00);
    wr(8'h91, 8'h05);
    repeat (32)
    begin
      repeat (2) @(posedge sys_clk);
      ext_clk <= ~ext_clk;
    end
    repeat (6) @(posedge sys_clk);
    wr(8'h91, 8'h00);
    rd(8'h94, 8'h02);
    wr(8'h94, 8'hcd);
    wr(8'h95, 8'hab);
    wr(8'h91, 8'h10);
    lfo_out <= 1'b0;
    wait_irq(1'b1);
    rd(8'h92, 8'hcd);
    rd(8'h93, 8'hab);
    complete_run();
  end
endmodule
